/* File: logic/hbc_h_bridge_control.sv */
// control and protection logic for one half of a dual h-bridge driver
// assumes control pins and comparator outputs arrive as digital levels,
// pin float status comes from the pad keepers, registers over avalon-mm
//
// Notes on behaviour
// RULE_01: each polarity input drives its own output
// RULE_02: active-high disable tri-states both outputs only
// RULE_03: blanking timer restarts on every output transition
// RULE_04: enable low tri-states outputs immediately
// RULE_05: enable low means sleep mode
// RULE_06: fully operational only with enable high
// RULE_07: floating enable reads low, stays asleep
// RULE_08: forward, reverse and free-wheel from polarity pair
// RULE_09: floating polarity or disable reads high
// RULE_10: flag low while disabled, high asleep
// RULE_11: high impedance switches all four transistors off
// RULE_12: under-voltage tri-states, recovers without toggling
// RULE_13: short or over-temperature latches off, flag low
// RULE_14: disable fall or enable rise clears latch
// RULE_15: otherwise outputs follow the control inputs
// RULE_16: over-limit current chops instead of latching
// RULE_17: limit reached gives fixed off time
// RULE_18: limit ignored during blanking window
// RULE_19: thermal clear needs temperature below hysteresis
// RULE_20: timers count clock, comparators synchronised
// RULE_21: reset clears latched faults
//
// The placing of the registers and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
module hbc_h_bridge_control
  import hbc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire hbc_ctrl_t ctrlPins,
  input wire hbc_ctrl_t ctrlFloating,
  input wire logic [CMP_N-1:0] comparators,
  output hbc_gates_t gates,
  output logic bridgeOutADriven,
  output logic bridgeOutBDriven,
  output logic faultFlagNOut,
  output logic faultFlagNOe,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  // ==========================================================
  // resolved control inputs
  logic polA;
  logic polB;
  logic disHigh;
  logic enHigh;
  logic sleepMode;
  logic outputsOff;

  assign polA = ctrlFloating.polarityInA ? 1'b1 : ctrlPins.polarityInA; // see RULE_09
  assign polB = ctrlFloating.polarityInB ? 1'b1 : ctrlPins.polarityInB; // see RULE_09
  assign disHigh = ctrlFloating.disableActiveHigh ? 1'b1 : ctrlPins.disableActiveHigh; // see RULE_09
  assign enHigh = ctrlFloating.enableOrDisableLow ? 1'b0 : ctrlPins.enableOrDisableLow; // see RULE_07
  assign sleepMode = ~enHigh; // see RULE_05
  assign outputsOff = sleepMode | disHigh; // see RULE_02, see RULE_04

  // ==========================================================
  // comparator synchronisers
  logic [CMP_N-1:0] cmpMeta;
  logic [CMP_N-1:0] cmpSync;

  // first stage read only by the second
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cmpMeta <= '0;
      cmpSync <= '0;
    end
    else
    begin
      cmpMeta <= comparators; // see RULE_20
      cmpSync <= cmpMeta;
    end
  end

  logic underVoltage;
  assign underVoltage = cmpSync[CMP_UV];

  // ==========================================================
  // fault clearing edges
  logic disPrev;
  logic enPrev;
  logic clearEdge;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      disPrev <= 1'b0;
      enPrev <= 1'b0;
    end
    else
    begin
      disPrev <= disHigh;
      enPrev <= enHigh;
    end
  end

  assign clearEdge = (disPrev & ~disHigh) | (~enPrev & enHigh); // see RULE_14

  // ==========================================================
  // fault latches
  logic shortLatched;
  logic thermalLatched;
  logic faultLatched;
  logic anyDriven;
  logic shortSet;
  logic hotSet;

  assign faultLatched = shortLatched | thermalLatched;
  assign anyDriven = gates.highA | gates.lowA | gates.highB | gates.lowB;
  // a short only shows while a transistor conducts
  assign shortSet = cmpSync[CMP_SHORT] & anyDriven;
  assign hotSet = cmpSync[CMP_HOT] & enHigh;

  // set wins over a clearing edge in the same cycle
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      shortLatched <= 1'b0; // see RULE_21
    else if (shortSet)
      shortLatched <= 1'b1; // see RULE_13
    else if (clearEdge)
      shortLatched <= 1'b0; // see RULE_14
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      thermalLatched <= 1'b0; // see RULE_21
    else if (hotSet)
      thermalLatched <= 1'b1; // see RULE_13
    else if (clearEdge && cmpSync[CMP_COOL])
      thermalLatched <= 1'b0; // see RULE_19
  end

  // ==========================================================
  // timer settings and blanking / constant-off chopping
  logic [TIMER_W-1:0] blankCyclesReg;
  logic [TIMER_W-1:0] offCyclesReg;
  logic [TIMER_W-1:0] blankCnt;
  logic [TIMER_W-1:0] offCnt;
  hbc_chop_t chopState;
  logic blanking;
  logic driveAllowed;
  hbc_gates_t gatesNext;
  logic transition;

  assign blanking = blankCnt != '0;
  assign driveAllowed = ~outputsOff & ~underVoltage & ~faultLatched & (chopState == CHOP_IDLE); // see RULE_06, see RULE_12, see RULE_15

  always_comb
  begin
    gatesNext = '0; // see RULE_11
    if (driveAllowed)
    begin
      gatesNext.highA = polA; // see RULE_01, see RULE_08
      gatesNext.lowA = ~polA;
      gatesNext.highB = polB;
      gatesNext.lowB = ~polB;
    end
  end

  assign transition = gatesNext != gates;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      gates <= '0;
    else
      gates <= gatesNext;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      blankCnt <= '0;
    else if (transition)
      blankCnt <= blankCyclesReg; // see RULE_03
    else if (blanking)
      blankCnt <= blankCnt - 1'b1; // see RULE_20
  end

  // chopping regulates rather than latches; zero off time means no pause
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      chopState <= CHOP_IDLE;
      offCnt <= '0;
    end
    else
    begin
      case (chopState)
        CHOP_IDLE:
        begin
          if (cmpSync[CMP_CURRENT_LIMIT_THRESHOLD] && anyDriven && !blanking && !transition && offCyclesReg != '0) // see RULE_16, see RULE_18
          begin
            chopState <= CHOP_OFF; // see RULE_17
            offCnt <= offCyclesReg;
          end
        end
        CHOP_OFF:
        begin
          if (offCnt <= 16'h0001)
          begin
            chopState <= CHOP_IDLE;
            offCnt <= '0;
          end
          else
            offCnt <= offCnt - 1'b1;
        end
        default:
        begin
          chopState <= CHOP_IDLE;
          offCnt <= '0;
        end
      endcase
    end
  end

  // ==========================================================
  // outputs and status flag
  logic flagHigh;

  assign bridgeOutADriven = gates.highA | gates.lowA;
  assign bridgeOutBDriven = gates.highB | gates.lowB;
  assign flagHigh = sleepMode | ~(disHigh | underVoltage | faultLatched); // see RULE_10, see RULE_12, see RULE_13
  // open drain: only ever pulls low
  assign faultFlagNOut = 1'b0;
  assign faultFlagNOe = ~flagHigh;

  // ==========================================================
  // avalon-mm slave, one wait state per access
  logic ackReg;
  logic busReq;
  logic [31:0] statusWord;

  assign busReq = avs_read | avs_write;
  assign avs_waitrequest = busReq & ~ackReg;

  always_comb
  begin
    statusWord = '0;
    statusWord[ST_SHORT_LATCHED] = shortLatched;
    statusWord[ST_THERMAL_LATCHED] = thermalLatched;
    statusWord[ST_SLEEP] = sleepMode;
    statusWord[ST_DISABLED] = disHigh;
    statusWord[ST_UNDER_VOLTAGE] = underVoltage;
    statusWord[ST_CHOPPING] = chopState == CHOP_OFF;
    statusWord[ST_BLANKING] = blanking;
    statusWord[ST_FLAG_HIGH] = flagHigh;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      ackReg <= 1'b0;
    else
      ackReg <= busReq & ~ackReg;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      avs_readdata <= '0;
    else if (avs_read && !ackReg)
    begin
      case (avs_address)
        BLANK_CYCLES_OFS: avs_readdata <= {16'h0000, blankCyclesReg};
        OFF_CYCLES_OFS: avs_readdata <= {16'h0000, offCyclesReg};
        STATUS_OFS: avs_readdata <= statusWord;
        default: avs_readdata <= '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      blankCyclesReg <= BLANK_CYCLES_RST;
      offCyclesReg <= OFF_CYCLES_RST;
    end
    else if (avs_write && ackReg)
    begin
      case (avs_address)
        BLANK_CYCLES_OFS: blankCyclesReg <= avs_writedata[TIMER_W-1:0]; // see RULE_20
        OFF_CYCLES_OFS: offCyclesReg <= avs_writedata[TIMER_W-1:0]; // see RULE_20
        default: ;
      endcase
    end
  end

endmodule

/* File: logic/hbc_pkg.sv */
// constants and carrier types for the h-bridge control and protection block
// assumes one 10 MHz clock and an avalon-mm master for the timer settings
package hbc_pkg;
  // ==========================================================
  // clock and timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int BLANK_TIME_NS = 16500;
  localparam int OFF_TIME_NS = 20000;
  localparam int TIMER_W = 16;
  // typical figures, rounded up to whole cycles
  localparam logic [TIMER_W-1:0] BLANK_CYCLES_RST =
    TIMER_W'((BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TIMER_W-1:0] OFF_CYCLES_RST =
    TIMER_W'((OFF_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ==========================================================
  // register map, byte addresses
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] BLANK_CYCLES_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_CYCLES_OFS = 4'h4;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h8;

  // status register bit positions
  localparam int ST_SHORT_LATCHED = 0;
  localparam int ST_THERMAL_LATCHED = 1;
  localparam int ST_SLEEP = 2;
  localparam int ST_DISABLED = 3;
  localparam int ST_UNDER_VOLTAGE = 4;
  localparam int ST_CHOPPING = 5;
  localparam int ST_BLANKING = 6;
  localparam int ST_FLAG_HIGH = 7;

  // comparator vector positions
  localparam int CMP_N = 5;
  localparam int CMP_CURRENT_LIMIT_THRESHOLD = 0;
  localparam int CMP_SHORT = 1;
  localparam int CMP_HOT = 2;
  localparam int CMP_COOL = 3;
  localparam int CMP_UV = 4;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic polarityInA;
    logic polarityInB;
    logic disableActiveHigh;
    logic enableOrDisableLow;
  } hbc_ctrl_t;

  // one gate per power transistor
  typedef struct packed {
    logic highA;
    logic lowA;
    logic highB;
    logic lowB;
  } hbc_gates_t;

  typedef enum logic [1:0] {CHOP_IDLE, CHOP_OFF} hbc_chop_t;
endpackage

/* File: sim/h_bridge_control_protection_bench.sv */
// self-checking bench for the h-bridge control and protection block
// assumes the host model owns the pins, the bench the comparators and bus
`timescale 1ns/1ps
module h_bridge_control_protection_bench
  import hbc_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [CMP_N-1:0] cmp = 5'h08;
  logic [ADDR_W-1:0] avsAddr = 4'h0;
  logic avsRd = 1'b0;
  logic avsWr = 1'b0;
  logic [31:0] avsWd = 32'h0;
  logic [31:0] avsRdata;
  logic [31:0] rd;
  logic avsWait;
  logic oe;
  logic flagOut;
  hbc_ctrl_t ctrlPins;
  hbc_ctrl_t ctrlFloating;
  hbc_gates_t gates;
  int error_cnt = 0;
  int n_tests = 0;
  int k;
  // pins, floating, gates, flag pulled
  logic [12:0] tbl [10] = '{{4'h9, 4'h0, 4'h9, 1'b0}, {4'h5, 4'h0, 4'h6, 1'b0}, {4'h1, 4'h0, 4'h5, 1'b0},
    {4'hD, 4'h0, 4'hA, 1'b0}, {4'h3, 4'h0, 4'h0, 1'b1}, {4'h0, 4'h0, 4'h0, 1'b0}, {4'h1, 4'h8, 4'h9, 1'b0},
    {4'h1, 4'h2, 4'h0, 1'b1}, {4'hD, 4'h1, 4'h0, 1'b0}, {4'h9, 4'h4, 4'hA, 1'b0}};
  hbc_host_model host (.sys_clk(sys_clk), .ctrlPins(ctrlPins), .ctrlFloating(ctrlFloating));
  hbc_h_bridge_control DUT (.sys_clk(sys_clk), .rst_b(rst_b), .ctrlPins(ctrlPins), .ctrlFloating(ctrlFloating),
    .comparators(cmp), .gates(gates), .bridgeOutADriven(), .bridgeOutBDriven(), .faultFlagNOut(flagOut),
    .faultFlagNOe(oe), .avs_address(avsAddr), .avs_read(avsRd), .avs_write(avsWr), .avs_writedata(avsWd),
    .avs_readdata(avsRdata), .avs_waitrequest(avsWait));
  // ==========================================
  // tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic outs(input logic [3:0] g, input logic f);
    chk(32'(gates), 32'(g));
    chk(32'(oe), 32'(f));
    chk(32'(flagOut), 32'h0);
  endtask
  task automatic setc(input logic [4:0] v);
    @(posedge sys_clk);
    cmp <= v;
  endtask
  // request stands until a rising edge samples waitrequest low; data taken at that edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avsAddr <= a;
    avsWd <= d;
    avsWr <= wr;
    avsRd <= !wr;
    do
      @(posedge sys_clk);
    while (avsWait !== 1'b0);
    rd = avsRdata;
    avsWr <= 1'b0;
    avsRd <= 1'b0;
  endtask
  task automatic stop_test;
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================
  // clock, watchdog, sequence
  initial
  begin
    forever #50 sys_clk = ~sys_clk;
  end
  initial
  begin
    #2000000;
    error_cnt++;
    stop_test;
  end
  initial
  begin
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 10; i++)
    begin
      host.drive(tbl[i][12:9], tbl[i][8:5]);
      wt(3);
      outs(tbl[i][4:1], tbl[i][0]);
    end
    host.drive(4'h9, 4'h0);
    setc(5'h0A);
    wt(4);
    setc(5'h08);
    wt(4);
    outs(4'h0, 1'b1);
    bus(1'b0, STATUS_OFS, 32'h0);
    chk(rd & 32'h3, 32'h1);
    host.toggle(4'h9, 4'h2);
    wt(3);
    outs(4'h9, 1'b0);
    setc(5'h04);
    wt(4);
    setc(5'h00);
    host.toggle(4'h9, 4'h1);
    wt(3);
    outs(4'h0, 1'b1);
    setc(5'h08);
    wt(3);
    host.toggle(4'h9, 4'h1);
    wt(3);
    outs(4'h9, 1'b0);
    setc(5'h18);
    wt(4);
    outs(4'h0, 1'b1);
    setc(5'h08);
    wt(4);
    outs(4'h9, 1'b0);
    setc(5'h0A);
    wt(4);
    setc(5'h08);
    rst_b <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    wt(3);
    outs(4'h9, 1'b0);
    bus(1'b0, BLANK_CYCLES_OFS, 32'h0);
    chk(rd, 32'd165);
    bus(1'b0, OFF_CYCLES_OFS, 32'h0);
    chk(rd, 32'd200);
    bus(1'b1, 4'hC, 32'h5);
    bus(1'b0, 4'hC, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, BLANK_CYCLES_OFS, 32'h28);
    bus(1'b1, OFF_CYCLES_OFS, 32'h6);
    bus(1'b0, BLANK_CYCLES_OFS, 32'h0);
    chk(rd, 32'h28);
    host.drive(4'h5, 4'h0);
    setc(5'h09);
    wt(30);
    chk(32'(gates), 32'h6);
    for (k = 0; gates !== 4'h0 && k < 40; k++)
      wt(1);
    // blanking of 0x28 cycles from the re-drive edge, then one edge to chop, one to gate off
    chk(32'(k), 32'd13);
    // limit stays high: the re-drive restarts blanking, so no second chop
    for (k = 0; gates === 4'h0 && k < 40; k++)
      wt(1);
    chk(32'(k), 32'd6);
    chk(32'(gates), 32'h6);
    stop_test;
  end
endmodule

/* File: sim/hbc_h_bridge_control_properties.sv */
// checker for the h-bridge control and protection block
// assumes one clock, bound onto the design top below
`timescale 1ns/1ps
module hbc_check_props
  import hbc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire hbc_ctrl_t ctrlPins,
  input wire hbc_ctrl_t ctrlFloating,
  input wire logic [CMP_N-1:0] comparators,
  input wire hbc_gates_t gates,
  input wire logic bridgeOutADriven,
  input wire logic bridgeOutBDriven,
  input wire logic faultFlagNOe
);
  // ==========================================
  // resolved pins, float wins over level
  wire en = ctrlPins.enableOrDisableLow & ~ctrlFloating.enableOrDisableLow;
  wire dis = ctrlPins.disableActiveHigh | ctrlFloating.disableActiveHigh;
  wire resA = ctrlPins.polarityInA | ctrlFloating.polarityInA;
  wire resB = ctrlPins.polarityInB | ctrlFloating.polarityInB;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // ==========================================
  a_sleep_flag_high: assert property (!en |-> !faultFlagNOe)
    else $error("flag pulled in sleep");
  a_disable_flag_low: assert property (en && dis |-> faultFlagNOe)
    else $error("flag free while disabled");
  a_disable_gates_off: assert property (dis || !en |=> gates == '0)
    else $error("gates on while disabled");
  a_hiz_all_off: assert property (bridgeOutADriven == (gates.highA | gates.lowA) && !(gates.highB & gates.lowB)
    && !(gates.highA & gates.lowA)
    && bridgeOutBDriven == (gates.highB | gates.lowB))
    else $error("driven flag and gates disagree");
  a_out_a_polarity: assert property (gates.highA || gates.lowA |-> gates.highA == $past(resA))
    else $error("output a wrong level");
  a_out_b_polarity: assert property (gates.highB || gates.lowB |-> gates.highB == $past(resB))
    else $error("output b wrong level");
  a_uv_shuts_down: assert property ((comparators[CMP_UV] && en) [*3] |-> faultFlagNOe ##1 gates == '0)
    else $error("under-voltage ignored");
  a_short_latches: assert property ((comparators[CMP_SHORT] && gates != '0 && en && !dis) [*3]
    |-> ##[1:3] (faultFlagNOe || !en))
    else $error("short not latched");
  a_fault_clears: assert property ((en && comparators == 5'h08) [*3] ##0 $fell(dis)
    |=> (!faultFlagNOe || dis || !en))
    else $error("latch not cleared");
endmodule

bind hbc_h_bridge_control hbc_check_props chk (.sys_clk(sys_clk), .rst_b(rst_b), .ctrlPins(ctrlPins),
  .ctrlFloating(ctrlFloating), .comparators(comparators), .gates(gates), .bridgeOutADriven(bridgeOutADriven),
  .bridgeOutBDriven(bridgeOutBDriven), .faultFlagNOe(faultFlagNOe));

/* File: sim/hbc_host_model.sv */
// host controller model that drives the four control pins
// assumes the bench calls its tasks; pins move just after a rising edge
`timescale 1ns/1ps
module hbc_host_model
  import hbc_pkg::*;
(
  input wire logic sys_clk,
  output hbc_ctrl_t ctrlPins,
  output hbc_ctrl_t ctrlFloating
);
  initial
  begin
    ctrlPins = 4'h1;
    ctrlFloating = 4'h0;
  end
  // ==========================================
  // a released pin shows the inverse of its last level, never a held copy
  task automatic drive(input logic [3:0] p, input logic [3:0] f);
    @(posedge sys_clk);
    ctrlPins <= (p & ~f) | (~ctrlPins & f);
    ctrlFloating <= f;
  endtask
  // flip the masked pin and back: disable fall or enable rise
  task automatic toggle(input logic [3:0] p, input logic [3:0] m);
    drive(p ^ m, 4'h0);
    drive(p, 4'h0);
  endtask
endmodule
